// >>> pkg/rscd_pkg.sv
// Purpose: Shared constants and types for the reset strap configuration decoder.
// Assumes: Strap class codes come from an external resistor-sense front end.
// Notes:   All encodings used by more than one file live here.

package rscd_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PORTS   = 2;
    localparam int unsigned CLASS_W     = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Strap word layout, lowest bit of each class field
    // ------------------------------------------------------------------
    localparam int unsigned STRAP_W      = 12;
    localparam int unsigned FLD_DATA_OUT = 10;
    localparam int unsigned FLD_CLOCK    = 8;
    localparam int unsigned FLD_FIXED    = 6;
    localparam int unsigned FLD_CHARGE   = 4;
    localparam int unsigned FLD_POS      = 2;
    localparam int unsigned FLD_NEG      = 0;

    // ------------------------------------------------------------------
    // Strap class codes from the resistor-sense front end
    // ------------------------------------------------------------------
    localparam logic [1:0] CLASS_WEAK_DOWN   = 2'h0;
    localparam logic [1:0] CLASS_WEAK_UP     = 2'h1;
    localparam logic [1:0] CLASS_STRONG_DOWN = 2'h2;

    // Two-level serial strap class: pull-up seen, or nothing seen.
    localparam logic [1:0] SER_NONE   = 2'h0;
    localparam logic [1:0] SER_PULLUP = 2'h1;

    // ------------------------------------------------------------------
    // Decoded per-port masks, bit 0 is port 1
    // ------------------------------------------------------------------
    localparam logic [1:0] MASK_NONE  = 2'h0;
    localparam logic [1:0] MASK_P1    = 2'h1;
    localparam logic [1:0] MASK_P1_P2 = 2'h3;

    // ------------------------------------------------------------------
    // Serial pin mode
    // ------------------------------------------------------------------
    localparam logic MODE_SPI   = 1'b0;
    localparam logic MODE_SMBUS = 1'b1;

    // ------------------------------------------------------------------
    // Boot sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET     = 4'h1,
        ST_LATCH     = 4'h2,
        ST_HOST_CFG  = 4'h4,
        ST_OTP_CFG   = 4'h8
    } rscd_state_type;

endpackage

// >>> verilog/rscd_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin-level inputs.
// Assumes: Each bit is a slowly moving level; no word coherence is needed.
// Notes:   The first stage feeds only the second stage. There is no reset.

`timescale 1ns/10ps

module rscd_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_i, // Core clock.
    input  wire logic [WIDTH-1:0] async_i,    // Asynchronous inputs.
    output logic      [WIDTH-1:0] sync_o      // Synchronised outputs.
);

    logic [WIDTH-1:0] stage1;

    // The flops keep sampling while the core is held in reset, so the level
    // handed over at release is the pin level and not a cleared value.
    always_ff @(posedge core_clk_i) begin
        stage1 <= async_i;
        sync_o <= stage1;
    end

endmodule

// >>> verilog/rscd_top.sv
// Purpose: Captures board configuration straps at reset release and decodes them.
// Assumes: Strap pins are stable while reset is held; classes come pre-sensed.
// Notes:   Straps are read once per reset; later pin traffic is ignored.

`timescale 1ns/10ps

module rscd_top (
    input  wire logic       core_clk_i,             // Core clock, 50 MHz.
    input  wire logic       rst_n_i,                // Reset, sync, active low.
    input  wire logic [1:0] data_out_class_i,       // Serial data-out strap class.
    input  wire logic [1:0] clock_class_i,          // Serial clock strap class.
    input  wire logic [1:0] fixed_port_strap_i,     // Fixed-port strap class.
    input  wire logic [1:0] charging_strap_i,       // Charging strap class.
    input  wire logic [1:0] port_pos_line_off_i,    // Positive-line off straps.
    input  wire logic [1:0] port_neg_line_off_i,    // Negative-line off straps.
    input  wire logic       cfg_end_write_i,        // End-of-config write pulse.
    output logic            smbus_mode_o,           // 1 SMBus slave, 0 SPI master.
    output logic            pins_functional_o,      // Pins in functional role.
    output logic            spi_pins_en_o,          // SPI pin functions enabled.
    output logic            smbus_pins_en_o,        // SMBus pin functions enabled.
    output logic [1:0]      usb2_port_off_o,        // USB 2.0 port disabled mask.
    output logic [1:0]      usb3_port_off_o,        // USB 3 port disabled mask.
    output logic [1:0]      pos_line_off_o,         // Positive line disabled mask.
    output logic [1:0]      neg_line_off_o,         // Negative line disabled mask.
    output logic [1:0]      fixed_port_o,           // Non-removable port mask.
    output logic [1:0]      charge_en_o,            // Charging enabled port mask.
    output logic            host_cfg_stage_o,       // In host-configuration stage.
    output logic            otp_cfg_stage_o         // In OTP configuration stage.
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    // The synchroniser carries no reset: it keeps sampling while the core is
    // held in reset, so the level it hands over at release is the strap fit
    // itself and not a cleared flop.
    logic [rscd_pkg::STRAP_W-1:0] pins_sync;
    logic [rscd_pkg::STRAP_W-1:0] pins_raw;

    assign pins_raw = {data_out_class_i, clock_class_i, fixed_port_strap_i,
                       charging_strap_i, port_pos_line_off_i, port_neg_line_off_i};

    rscd_sync #(
        .WIDTH      (rscd_pkg::STRAP_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .async_i    (pins_raw),
        .sync_o     (pins_sync)
    );

    // Field order follows the concatenation above, data-out class on top.
    wire [1:0] s_data_out = pins_sync[rscd_pkg::FLD_DATA_OUT +: rscd_pkg::CLASS_W];
    wire [1:0] s_clock    = pins_sync[rscd_pkg::FLD_CLOCK +: rscd_pkg::CLASS_W];
    wire [1:0] s_fixed    = pins_sync[rscd_pkg::FLD_FIXED +: rscd_pkg::CLASS_W];
    wire [1:0] s_charge   = pins_sync[rscd_pkg::FLD_CHARGE +: rscd_pkg::CLASS_W];
    wire [1:0] s_pos      = pins_sync[rscd_pkg::FLD_POS +: rscd_pkg::CLASS_W];
    wire [1:0] s_neg      = pins_sync[rscd_pkg::FLD_NEG +: rscd_pkg::CLASS_W];

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Both three-level straps share one encoding, so one function serves.
    // Class 3 is never fitted on a board; it lands in the default branch so a
    // sensing glitch gives the safest setting rather than an odd mask.
    function automatic logic [1:0] decode_three_level(input logic [1:0] cls);
        case (cls)
            rscd_pkg::CLASS_WEAK_UP:     decode_three_level = rscd_pkg::MASK_P1;
            rscd_pkg::CLASS_STRONG_DOWN: decode_three_level = rscd_pkg::MASK_P1_P2;
            default:                     decode_three_level = rscd_pkg::MASK_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // The capture flops load once, on the first edge after release. The
    // synchroniser delay means the value taken is the pin level two edges
    // earlier, still inside reset, which the board must hold stable; later
    // pin traffic cannot reach the decode.
    logic [1:0] cap_data_out;
    logic [1:0] cap_clock;
    logic [1:0] cap_fixed;
    logic [1:0] cap_charge;
    logic [1:0] cap_pos;
    logic [1:0] cap_neg;
    // Set once per reset; nothing but reset clears it.
    logic       captured;

    rscd_pkg::rscd_state_type state;
    rscd_pkg::rscd_state_type next_state;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cap_data_out <= rscd_pkg::SER_NONE;
            cap_clock    <= rscd_pkg::SER_NONE;
            cap_fixed    <= rscd_pkg::CLASS_WEAK_DOWN;
            cap_charge   <= rscd_pkg::CLASS_WEAK_DOWN;
            cap_pos      <= rscd_pkg::MASK_NONE;
            cap_neg      <= rscd_pkg::MASK_NONE;
            captured     <= 1'b0;
        end else if (!captured) begin
            cap_data_out <= s_data_out;
            cap_clock    <= s_clock;
            cap_fixed    <= s_fixed;
            cap_charge   <= s_charge;
            cap_pos      <= s_pos;
            cap_neg      <= s_neg;
            captured     <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Decode of captured straps
    // ------------------------------------------------------------------
    // Only a pull-up on both serial straps means a host is fitted; any other
    // fit, odd codes included, falls back to SPI, which needs no host.
    wire       smbus_sel = (cap_data_out == rscd_pkg::SER_PULLUP) &&
                           (cap_clock == rscd_pkg::SER_PULLUP);
    wire [1:0] pos_off   = cap_pos;
    wire [1:0] neg_off   = cap_neg;
    // One high line strap only parks that line; the port goes off with both.
    wire [1:0] port_off  = pos_off & neg_off;
    wire [1:0] fixed_dec = decode_three_level(cap_fixed);
    wire [1:0] chg_dec   = decode_three_level(cap_charge);

    // ------------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            rscd_pkg::ST_RESET: begin
                // Leave on the first edge with reset released.
                next_state = rscd_pkg::ST_LATCH;
            end
            rscd_pkg::ST_LATCH: begin
                if (captured) begin
                    next_state = smbus_sel ? rscd_pkg::ST_HOST_CFG
                                           : rscd_pkg::ST_OTP_CFG;
                end
            end
            rscd_pkg::ST_HOST_CFG: begin
                // No timeout: a host that never writes keeps the hub here.
                if (cfg_end_write_i) begin
                    next_state = rscd_pkg::ST_OTP_CFG;
                end
            end
            rscd_pkg::ST_OTP_CFG: begin
                // Final stage: only a new reset leaves it, so late writes are ignored.
                next_state = rscd_pkg::ST_OTP_CFG;
            end
            default: begin
                // A corrupted state code restarts the sequence rather than locking it.
                next_state = rscd_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state <= rscd_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Decoded outputs load exactly once, as the sequencer leaves the latch stage.
    wire leaving_latch = (state == rscd_pkg::ST_LATCH) && captured;

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            smbus_mode_o      <= rscd_pkg::MODE_SPI;
            pins_functional_o <= 1'b0;
            spi_pins_en_o     <= 1'b0;
            smbus_pins_en_o   <= 1'b0;
            usb2_port_off_o   <= rscd_pkg::MASK_NONE;
            usb3_port_off_o   <= rscd_pkg::MASK_NONE;
            pos_line_off_o    <= rscd_pkg::MASK_NONE;
            neg_line_off_o    <= rscd_pkg::MASK_NONE;
            fixed_port_o      <= rscd_pkg::MASK_NONE;
            charge_en_o       <= rscd_pkg::MASK_NONE;
            host_cfg_stage_o  <= 1'b0;
            otp_cfg_stage_o   <= 1'b0;
        end else begin
            if (leaving_latch) begin
                smbus_mode_o      <= smbus_sel;
                pins_functional_o <= 1'b1;
                spi_pins_en_o     <= !smbus_sel;
                smbus_pins_en_o   <= smbus_sel;
                usb2_port_off_o   <= port_off;
                usb3_port_off_o   <= port_off;
                pos_line_off_o    <= pos_off;
                neg_line_off_o    <= neg_off;
                fixed_port_o      <= fixed_dec;
                charge_en_o       <= chg_dec;
            end
            // Stage outputs follow next_state so they change on the same edge as
            // the state register; one compare each, but no extra cycle of delay.
            host_cfg_stage_o <= (next_state == rscd_pkg::ST_HOST_CFG);
            otp_cfg_stage_o  <= (next_state == rscd_pkg::ST_OTP_CFG);
        end
    end

endmodule

// >>> test/rscd_checker.sv
// Purpose: Port-level checks of the strap decoder.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every rscd_top instance.
`timescale 1ns/10ps
module rscd_checker (
    input  wire logic       core_clk_i,        // Core clock.
    input  wire logic       rst_n_i,           // Reset, active low.
    input  wire logic       cfg_end_write_i,   // End-of-config write pulse.
    input  wire logic       smbus_mode_o,      // Serial mode.
    input  wire logic       pins_functional_o, // Pins in functional role.
    input  wire logic       spi_pins_en_o,     // SPI pin roles.
    input  wire logic       smbus_pins_en_o,   // SMBus pin roles.
    input  wire logic [1:0] usb2_port_off_o,   // USB 2.0 off mask.
    input  wire logic [1:0] usb3_port_off_o,   // USB 3 off mask.
    input  wire logic [1:0] pos_line_off_o,    // Positive line off mask.
    input  wire logic [1:0] neg_line_off_o,    // Negative line off mask.
    input  wire logic [1:0] fixed_port_o,      // Non-removable mask.
    input  wire logic [1:0] charge_en_o,       // Charging mask.
    input  wire logic       host_cfg_stage_o,  // Host stage.
    input  wire logic       otp_cfg_stage_o    // OTP stage.
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_first_decode;
        pins_functional_o && !$past(pins_functional_o);
    endsequence
    sequence s_end_write;
        host_cfg_stage_o && cfg_end_write_i;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) !rst_n_i |=>
        !smbus_mode_o && !pins_functional_o && !host_cfg_stage_o && fixed_port_o == 2'h0)
        else $error("outputs not cleared by reset");
    a_stage_choice: assert property (s_first_decode |->
        host_cfg_stage_o == smbus_mode_o && otp_cfg_stage_o != smbus_mode_o)
        else $error("wrong stage after capture");
    a_end_write: assert property (s_end_write |=> otp_cfg_stage_o && !host_cfg_stage_o)
        else $error("end write did not leave host stage");
    a_host_waits: assert property (host_cfg_stage_o && !cfg_end_write_i |=> host_cfg_stage_o)
        else $error("host stage left without write");
    a_decode_held: assert property (pins_functional_o |=> $stable(fixed_port_o) &&
        $stable(charge_en_o) && $stable(usb2_port_off_o) && $stable(smbus_mode_o))
        else $error("decoded straps changed after capture");
    a_port_both: assert property (usb2_port_off_o == (pos_line_off_o & neg_line_off_o))
        else $error("port off not both lines");
    a_usb3_pair: assert property (usb3_port_off_o == usb2_port_off_o)
        else $error("usb3 port not paired");
    a_pin_roles: assert property (pins_functional_o |-> smbus_pins_en_o == smbus_mode_o &&
        spi_pins_en_o == !smbus_mode_o)
        else $error("pin roles do not match mode");
    a_no_roles_early: assert property (!pins_functional_o |-> !spi_pins_en_o && !smbus_pins_en_o)
        else $error("pin roles before capture");
    a_masks_legal: assert property (fixed_port_o != 2'h2 && charge_en_o != 2'h2)
        else $error("illegal port mask");
endmodule
bind rscd_top rscd_checker u_chk (.*);

// >>> test/rscd_straps.sv
// Purpose: Board strap resistors as seen through the sense front end.
// Assumes: Setting word is held by the bench across each reset.
// Notes:   After capture the pins carry functional traffic, modelled as a toggling pattern.
`timescale 1ns/10ps
module rscd_straps (
    input  wire logic        core_clk_i,          // Core clock.
    input  wire logic [11:0] setting_i,           // Resistor fit of the board.
    input  wire logic        scramble_i,          // Pins in functional use.
    output logic      [1:0]  data_out_class_o,    // Serial data-out class.
    output logic      [1:0]  clock_class_o,       // Serial clock class.
    output logic      [1:0]  fixed_port_strap_o,  // Fixed-port class.
    output logic      [1:0]  charging_strap_o,    // Charging class.
    output logic      [1:0]  port_pos_line_off_o, // Positive-line straps.
    output logic      [1:0]  port_neg_line_off_o  // Negative-line straps.
);
    logic [11:0] wiggle = 12'h000;
    // Traffic changes every cycle so a stale capture cannot hide.
    always @(negedge core_clk_i) wiggle <= scramble_i ? ~wiggle : ~setting_i;
    assign {data_out_class_o, clock_class_o, fixed_port_strap_o, charging_strap_o,
            port_pos_line_off_o, port_neg_line_off_o} = scramble_i ? wiggle : setting_i;
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking bench for the strap decoder.
// Assumes: Straps held stable through reset by the board model.
// Notes:   Each scenario boots the block through a full reset.
`timescale 1ns/10ps
module testbench;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        cfg_end_write_i = 1'b0;
    logic        scramble   = 1'b0;
    logic [11:0] setting    = 12'h000;
    logic [1:0]  do_cls, ck_cls, fp_cls, ch_cls, pos_in, neg_in;
    logic [1:0]  usb2, usb3, pos_o, neg_o, fixed, charge;
    logic        smbus, pins_fn, spi_en, smb_en, host, otp;
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    always #10 core_clk_i = ~core_clk_i;
    rscd_straps board (.core_clk_i(core_clk_i), .setting_i(setting), .scramble_i(scramble),
        .data_out_class_o(do_cls), .clock_class_o(ck_cls), .fixed_port_strap_o(fp_cls),
        .charging_strap_o(ch_cls), .port_pos_line_off_o(pos_in), .port_neg_line_off_o(neg_in));
    rscd_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .data_out_class_i(do_cls),
        .clock_class_i(ck_cls), .fixed_port_strap_i(fp_cls), .charging_strap_i(ch_cls),
        .port_pos_line_off_i(pos_in), .port_neg_line_off_i(neg_in),
        .cfg_end_write_i(cfg_end_write_i), .smbus_mode_o(smbus), .pins_functional_o(pins_fn),
        .spi_pins_en_o(spi_en), .smbus_pins_en_o(smb_en), .usb2_port_off_o(usb2),
        .usb3_port_off_o(usb3), .pos_line_off_o(pos_o), .neg_line_off_o(neg_o),
        .fixed_port_o(fixed), .charge_en_o(charge), .host_cfg_stage_o(host),
        .otp_cfg_stage_o(otp));
    task automatic cmp(input string name, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [1:0] mask_of(input logic [1:0] cls);
        return (cls == 2'h1) ? 2'h1 : (cls == 2'h2) ? 2'h3 : 2'h0;
    endfunction
    task automatic boot(input logic [11:0] s);
        @(negedge core_clk_i);
        rst_n_i  = 1'b0;
        scramble = 1'b0;
        setting  = s;
        repeat (8) @(negedge core_clk_i);
        cmp("reset mode", 2'h0, {smbus, pins_fn});
        cmp("reset stage", 2'h0, {host, otp});
        rst_n_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
    endtask
    task automatic pulse_end;
        cfg_end_write_i = 1'b1;
        @(negedge core_clk_i);
        cfg_end_write_i = 1'b0;
        @(negedge core_clk_i);
    endtask
    task automatic test_decode;
        logic [1:0] i;
        logic       sm;
        for (int n = 0; n < 4; n++) begin
            i  = n[1:0];
            sm = (i == 2'h3);
            boot({1'b0, i[0], 1'b0, i[1], i, ~i, i, i ^ 2'h1});
            cmp("serial mode", {1'b0, sm}, {1'b0, smbus});
            cmp("pin roles", {sm, ~sm}, {smb_en, spi_en});
            cmp("functional", 2'h1, {1'b0, pins_fn});
            cmp("fixed ports", mask_of(i), fixed);
            cmp("charging", mask_of(~i), charge);
            cmp("pos lines", i, pos_o);
            cmp("neg lines", i ^ 2'h1, neg_o);
            cmp("usb2 off", i & (i ^ 2'h1), usb2);
            cmp("usb3 off", i & (i ^ 2'h1), usb3);
            cmp("stage", {sm, ~sm}, {host, otp});
        end
        $display("test_decode done");
    endtask
    task automatic test_hold_release;
        boot(12'h59f);
        scramble = 1'b1;
        repeat (20) @(negedge core_clk_i);
        cmp("held fixed", 2'h3, fixed);
        cmp("held charging", 2'h1, charge);
        cmp("held port off", 2'h3, usb3);
        cmp("held mode", 2'h1, {1'b0, smbus});
        cmp("host waits", 2'h2, {host, otp});
        pulse_end();
        cmp("after end write", 2'h1, {host, otp});
        pulse_end();
        cmp("write in otp", 2'h1, {host, otp});
        boot(12'hd00);
        cmp("odd serial class", 2'h1, {smb_en, spi_en});
        pulse_end();
        cmp("spi write ignored", 2'h1, {host, otp});
        $display("test_hold_release done");
    endtask
    task automatic results;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        test_decode();
        test_hold_release();
        results();
    end
endmodule
